// ==== core/b4s_ctl.sv ====
// Memory controller end of the burst SRAM bus, with its write buffer
`timescale 1ns/1ns
`include "b4s_regs.svh"
module b4s_fifo #(
  parameter int W = 40,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [PW:0] wp;
  logic [PW:0] rp;

  assign count = wp - rp;
  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rp[PW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wp <= '0;
    end else if (in_valid && in_ready) begin
      wp <= wp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (in_valid && in_ready) begin
      mem[wp[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rp <= '0;
    end else if (out_valid && out_ready) begin
      rp <= rp + 1'b1;
    end
  end
endmodule

module b4s_ctl #(
  parameter int AW = 6,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  b4s_if.ctl bus,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [AW-1:0] cmd_addr,
  output logic cmd_ready,
  input wire logic wr_valid,
  input wire logic [35:0] wr_data,
  input wire logic [3:0] wr_lane_en_n,
  output logic wr_ready,
  output logic rd_valid,
  output logic [35:0] rd_data,
  input wire logic clk_run,
  input wire logic out_clk_hold,
  output logic link_ready
);

  // ------------------------------------------------------------------
  // Clock generation and lock wait
  // ------------------------------------------------------------------
  b4s_pkg::b4s_ctl_state_e st;
  logic phase;
  logic [15:0] lock_cnt;
  logic [4:0] wpipe;
  logic [7:0] rpipe;
  logic busy;

  assign busy = (wpipe != 5'h00) | (rpipe != 8'h00);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= b4s_pkg::CS_LOCK;
      lock_cnt <= 16'h0000;
    end else begin
      case (st)
        b4s_pkg::CS_LOCK: begin
          lock_cnt <= lock_cnt + 16'h0001; // [R14]
          if (lock_cnt == 16'(`B4S_LOCK_CYC + `B4S_LOCK_MARGIN)) begin
            st <= b4s_pkg::CS_RUN;
          end
        end
        b4s_pkg::CS_RUN: begin
          // Stop only between bursts, with the true clock high
          if (!clk_run && !busy && phase) begin
            st <= b4s_pkg::CS_STOP;
          end
        end
        b4s_pkg::CS_STOP: begin
          if (clk_run) begin
            st <= b4s_pkg::CS_RUN;
          end
        end
        default: begin
          st <= b4s_pkg::CS_LOCK;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase <= 1'b0;
    end else if (st != b4s_pkg::CS_STOP) begin
      phase <= ~phase;
    end
  end

  // Parked clocks all sit high for the quickest restart [R04]
  assign bus.main_timing_true = (st == b4s_pkg::CS_STOP) | phase;
  assign bus.main_timing_inv = (st == b4s_pkg::CS_STOP) | ~phase;
  assign bus.output_timing_true = out_clk_hold | bus.main_timing_true; // [R05]
  assign bus.output_timing_inv = out_clk_hold | bus.main_timing_inv;
  assign bus.loop_bypass_n = 1'b1; // [R14]
  assign link_ready = (st == b4s_pkg::CS_RUN);

  // ------------------------------------------------------------------
  // Command issue
  // ------------------------------------------------------------------
  logic slot;
  logic last_rd;
  logic last_wr;
  logic issue_rd;
  logic issue_wr;
  logic [$clog2(FIFO_DEPTH):0] wq_count;
  logic wq_valid;
  logic [39:0] wq_data;
  logic pop;

  // Next edge is a true clock rise
  assign slot = (st == b4s_pkg::CS_RUN) & ~phase & clk_run;
  // Same kind never on consecutive rises; whole burst must be buffered [R09]
  assign cmd_ready = slot & (cmd_write ?
                     (~last_wr & (wq_count >= ($clog2(FIFO_DEPTH)+1)'(`B4S_WR_NEED))) :
                     ~last_rd);
  assign issue_rd = cmd_valid & cmd_ready & ~cmd_write;
  assign issue_wr = cmd_valid & cmd_ready & cmd_write; // [R13]

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      last_rd <= 1'b0;
      last_wr <= 1'b0;
      bus.read_select_n <= 1'b1;
      bus.write_select_n <= 1'b1;
      bus.addr <= '0;
    end else if (!phase) begin
      // Every slot edge, even with a park pending, so no select stays low
      last_rd <= issue_rd;
      last_wr <= issue_wr;
      bus.read_select_n <= ~issue_rd; // [R08]
      bus.write_select_n <= ~issue_wr; // [R01]
      if (issue_rd || issue_wr) begin
        bus.addr <= cmd_addr;
      end
    end
  end

  // ------------------------------------------------------------------
  // Write beats
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wpipe <= 5'h00;
    end else begin
      wpipe <= {wpipe[3:0], slot & issue_wr};
    end
  end

  assign pop = (wpipe[4:1] != 4'h0);

  b4s_fifo #(
    .W(40),
    .DEPTH(FIFO_DEPTH)
  ) u_wq (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_lane_en_n, wr_data}),
    .out_valid(wq_valid),
    .out_ready(pop),
    .out_data(wq_data),
    .count(wq_count)
  );

  // Beats land on the two true and two inverse rises after the command period [R01]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus.input_lane_bits <= 36'h000000000;
      {bus.lane3_write_en_n, bus.lane2_write_en_n,
       bus.lane1_write_en_n, bus.lane0_write_en_n} <= 4'hF;
    end else if (pop && wq_valid) begin
      bus.input_lane_bits <= wq_data[35:0];
      {bus.lane3_write_en_n, bus.lane2_write_en_n,
       bus.lane1_write_en_n, bus.lane0_write_en_n} <= wq_data[39:36]; // [R10] [R11]
    end else begin
      {bus.lane3_write_en_n, bus.lane2_write_en_n,
       bus.lane1_write_en_n, bus.lane0_write_en_n} <= 4'hF;
    end
  end

  // ------------------------------------------------------------------
  // Read capture
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rpipe <= 8'h00;
    end else begin
      rpipe <= {rpipe[6:0], slot & issue_rd};
    end
  end

  // Device data appears four to seven cycles after the command [R02]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_valid <= 1'b0;
      rd_data <= 36'h000000000;
    end else begin
      rd_valid <= (rpipe[7:4] != 4'h0);
      if (rpipe[7:4] != 4'h0) begin
        rd_data <= bus.output_bits;
      end
    end
  end

endmodule

// ==== core/b4s_if.sv ====
// Pin-level carrier between the memory controller and the SRAM device
`timescale 1ns/1ns
interface b4s_if #(
  parameter int AW = 6
);
  logic main_timing_true;
  logic main_timing_inv;
  logic output_timing_true;
  logic output_timing_inv;
  logic read_select_n;
  logic write_select_n;
  logic [AW-1:0] addr;
  logic [35:0] input_lane_bits;
  logic lane0_write_en_n;
  logic lane1_write_en_n;
  logic lane2_write_en_n;
  logic lane3_write_en_n;
  logic loop_bypass_n;
  logic [35:0] output_bits;
  logic output_bits_oe;
  logic returned_strobe_pos;
  logic returned_strobe_neg;

  modport dev (
    input main_timing_true, main_timing_inv, output_timing_true, output_timing_inv,
    input read_select_n, write_select_n, addr, input_lane_bits,
    input lane0_write_en_n, lane1_write_en_n, lane2_write_en_n, lane3_write_en_n,
    input loop_bypass_n,
    output output_bits, output_bits_oe, returned_strobe_pos, returned_strobe_neg
  );

  modport ctl (
    output main_timing_true, main_timing_inv, output_timing_true, output_timing_inv,
    output read_select_n, write_select_n, addr, input_lane_bits,
    output lane0_write_en_n, lane1_write_en_n, lane2_write_en_n, lane3_write_en_n,
    output loop_bypass_n,
    input output_bits, output_bits_oe, returned_strobe_pos, returned_strobe_neg
  );
endinterface

// ==== core/b4s_pkg.sv ====
// Types shared by both ends of the burst SRAM bus
package b4s_pkg;

  typedef logic [35:0] b4s_word_t;

  typedef enum logic [2:0] {
    CS_LOCK = 3'b001,
    CS_RUN = 3'b010,
    CS_STOP = 3'b100
  } b4s_ctl_state_e;

  typedef enum logic [1:0] {
    DS_POWERUP = 2'b01,
    DS_READY = 2'b10
  } b4s_dev_state_e;

endpackage

// ==== core/b4s_regs.svh ====
// Constants shared by both ends of the burst SRAM bus
`ifndef B4S_REGS_SVH
`define B4S_REGS_SVH

// ------------------------------------------------------------------
// Data layout
// ------------------------------------------------------------------
`define B4S_LANES 4
`define B4S_LANE_W 9
`define B4S_DATA_W 36
`define B4S_BURST 4
`define B4S_BURST_LSB 2

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define B4S_CLK_NS 100
`define B4S_LOCK_NS 20000
// Strictly longer than the lock time, so one cycle on top
`define B4S_LOCK_CYC (`B4S_LOCK_NS / `B4S_CLK_NS + 1)
// Controller waits a little past the device's own count
`define B4S_LOCK_MARGIN 4
// Output edges skipped after a read command before the first beat
`define B4S_RD_LEAD 2
// Output edge step that carries the last read beat
`define B4S_RD_LAST 5
// Beats needed in the write buffer before a write is issued
`define B4S_WR_NEED 4

`endif

// ==== core/b4s_sram_dev.sv ====
// SRAM device end of the four-beat split-port burst bus
// Operation
// R01: Write command loads address, four beats follow
// R02: Read command returns four beats on output clocks
// R03: No command means idle, outputs high impedance
// R04: Stopped clocks keep all state unchanged
// R05: Hold output clocks high to use input clocks
// R06: Commands sampled only on true clock rise
// R07: Outputs stay high impedance through power-up
// R08: Read select ignored for write after read
// R09: Second of back-to-back same commands ignored
// R10: Active-low lane enables mask nine-bit lanes
// R11: Lane enables may change every write beat
// R12: Burst order base plus zero to three
// R13: Read and write overlap; read wins ties
// R14: Stable clock before operation locks timing loop
// R15: Echo strobes run freely beside read data
`timescale 1ns/1ns
`include "b4s_regs.svh"
module b4s_sram_dev #(
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic srst,
  b4s_if.dev bus
);

  localparam int DEPTH = 1 << (AW + `B4S_BURST_LSB);
  localparam int LW = `B4S_LANE_W;

  // ------------------------------------------------------------------
  // Timing edge detection
  // ------------------------------------------------------------------
  logic k_prev;
  logic kn_prev;
  logic c_prev;
  logic cn_prev;
  logic k_rise;
  logic kn_rise;
  logic c_hold;
  logic o_rise;

  // Previous levels reset high so a first high pin is no edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      k_prev <= 1'b1;
      kn_prev <= 1'b1;
      c_prev <= 1'b1;
      cn_prev <= 1'b1;
    end else begin
      k_prev <= bus.main_timing_true;
      kn_prev <= bus.main_timing_inv;
      c_prev <= bus.output_timing_true;
      cn_prev <= bus.output_timing_inv;
    end
  end

  // No edge arrives while the clocks stand still, so nothing moves [R04]
  assign k_rise = bus.main_timing_true & ~k_prev;
  assign kn_rise = bus.main_timing_inv & ~kn_prev;
  // Both output clocks high selects the input pair for launching [R05]
  assign c_hold = bus.output_timing_true & bus.output_timing_inv;
  assign o_rise = c_hold ? (k_rise | kn_rise) :
                  ((bus.output_timing_true & ~c_prev) | (bus.output_timing_inv & ~cn_prev));

  // ------------------------------------------------------------------
  // Power-up and loop lock
  // ------------------------------------------------------------------
  b4s_pkg::b4s_dev_state_e dev_st;
  logic [15:0] lock_cnt;

  // Lock needs a count of clock edges with the loop enabled; a bypass restarts it, a clock pause only holds it [R14]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dev_st <= b4s_pkg::DS_POWERUP;
      lock_cnt <= 16'h0000;
    end else if (!bus.loop_bypass_n) begin
      dev_st <= b4s_pkg::DS_POWERUP;
      lock_cnt <= 16'h0000;
    end else begin
      case (dev_st)
        b4s_pkg::DS_POWERUP: begin
          if (k_rise | kn_rise) begin
            lock_cnt <= lock_cnt + 16'h0001;
            if (lock_cnt == 16'(`B4S_LOCK_CYC - 1)) begin
              dev_st <= b4s_pkg::DS_READY;
            end
          end
        end
        b4s_pkg::DS_READY: begin
          dev_st <= b4s_pkg::DS_READY;
        end
        default: begin
          dev_st <= b4s_pkg::DS_POWERUP;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------
  logic ready;
  logic prev_rd_req;
  logic prev_wr_req;
  logic rd_go;
  logic wr_go;

  assign ready = (dev_st == b4s_pkg::DS_READY);

  // Raw select levels from the last true clock rise
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_rd_req <= 1'b0;
      prev_wr_req <= 1'b0;
    end else if (k_rise) begin
      prev_rd_req <= ~bus.read_select_n;
      prev_wr_req <= ~bus.write_select_n;
    end
  end

  // Only the true clock rise samples commands [R06]
  // A read repeated on the next rise is dropped [R09]
  assign rd_go = k_rise & ready & ~bus.read_select_n & ~prev_rd_req;
  // Read wins a tie [R13]; after a read the read select is not looked at [R08]
  // Both selects high starts nothing [R03]
  assign wr_go = k_rise & ready & ~bus.write_select_n & ~prev_wr_req & ~rd_go; // [R09]

  // ------------------------------------------------------------------
  // Write sequencer and storage
  // ------------------------------------------------------------------
  logic [35:0] mem [0:DEPTH-1];
  logic wr_pend;
  logic [AW-1:0] wr_pend_addr;
  logic wr_active;
  logic [1:0] wr_cnt;
  logic [AW-1:0] wr_addr;
  logic [3:0] lane_n;

  assign lane_n = {bus.lane3_write_en_n, bus.lane2_write_en_n,
                   bus.lane1_write_en_n, bus.lane0_write_en_n};

  // Pending slot lets a new write overlap the tail of the last one
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_pend_addr <= '0;
    end else if (wr_go) begin
      wr_pend <= 1'b1; // [R01]
      wr_pend_addr <= bus.addr;
    end else if (kn_rise) begin
      wr_pend <= 1'b0;
    end
  end

  // First beat waits out the inverse rise of the command period
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_active <= 1'b0;
      wr_cnt <= 2'h0;
      wr_addr <= '0;
    end else begin
      if (wr_active && (k_rise || kn_rise)) begin
        wr_cnt <= wr_cnt + 2'h1; // [R12]
        if (wr_cnt == 2'h3) begin
          wr_active <= 1'b0;
        end
      end
      if (kn_rise && wr_pend) begin
        wr_active <= 1'b1; // [R01]
        wr_cnt <= 2'h0;
        wr_addr <= wr_pend_addr;
      end
    end
  end

  // Beats taken on both input clock rises, lane by lane [R05] [R10]
  always_ff @(posedge ref_clk) begin
    if (!srst && wr_active && (k_rise || kn_rise)) begin
      for (int i = 0; i < `B4S_LANES; i++) begin
        if (!lane_n[i]) begin
          mem[{wr_addr, wr_cnt}][i*LW +: LW] <= bus.input_lane_bits[i*LW +: LW]; // [R11]
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Read sequencers
  // ------------------------------------------------------------------
  // Two slots: the next read may start before the last one has drained
  logic [1:0] rs_valid;
  logic [AW-1:0] rs_addr [0:1];
  logic [2:0] rs_step [0:1];
  logic rs_sel;
  logic beat_hit;
  logic [AW+1:0] beat_addr;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rs_valid <= 2'h0;
      rs_sel <= 1'b0;
      for (int s = 0; s < 2; s++) begin
        rs_addr[s] <= '0;
        rs_step[s] <= 3'h0;
      end
    end else begin
      if (o_rise) begin
        for (int s = 0; s < 2; s++) begin
          if (rs_valid[s]) begin
            rs_step[s] <= rs_step[s] + 3'h1;
            if (rs_step[s] == 3'(`B4S_RD_LAST)) begin
              rs_valid[s] <= 1'b0; // [R12]
            end
          end
        end
      end
      if (rd_go) begin
        rs_valid[rs_sel] <= 1'b1; // [R02]
        rs_step[rs_sel] <= 3'h0;
        rs_addr[rs_sel] <= bus.addr;
        rs_sel <= ~rs_sel;
      end
    end
  end

  // Only one slot is ever within its beat window
  always_comb begin
    beat_hit = 1'b0;
    beat_addr = '0;
    for (int s = 0; s < 2; s++) begin
      if (rs_valid[s] && rs_step[s] >= 3'(`B4S_RD_LEAD)) begin
        beat_hit = 1'b1;
        beat_addr = {rs_addr[s], 2'(rs_step[s] - 3'(`B4S_RD_LEAD))}; // [R12]
      end
    end
  end

  // ------------------------------------------------------------------
  // Output drivers
  // ------------------------------------------------------------------
  // Enable falls at the first output edge without a beat
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus.output_bits <= 36'h000000000;
      bus.output_bits_oe <= 1'b0; // [R07]
    end else if (!ready) begin
      bus.output_bits_oe <= 1'b0; // [R07]
    end else if (o_rise) begin
      bus.output_bits_oe <= beat_hit; // [R03]
      if (beat_hit) begin
        bus.output_bits <= mem[beat_addr]; // [R02]
      end
    end
  end

  // Echo copies the launching clock pair, so it stops only with it [R15]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus.returned_strobe_pos <= 1'b0;
      bus.returned_strobe_neg <= 1'b0;
    end else begin
      bus.returned_strobe_pos <= c_hold ? bus.main_timing_true : bus.output_timing_true;
      bus.returned_strobe_neg <= c_hold ? bus.main_timing_inv : bus.output_timing_inv;
    end
  end

endmodule

// ==== verification/b4s_chk.sv ====
// Pin-level assertions for the burst SRAM bus
`timescale 1ns/1ns
module b4s_chk (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic main_timing_true,
  input wire logic main_timing_inv,
  input wire logic output_timing_true,
  input wire logic output_timing_inv,
  input wire logic read_select_n,
  input wire logic write_select_n,
  input wire logic lane0_write_en_n,
  input wire logic lane1_write_en_n,
  input wire logic lane2_write_en_n,
  input wire logic lane3_write_en_n,
  input wire logic output_bits_oe,
  input wire logic returned_strobe_pos,
  input wire logic returned_strobe_neg
);
  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic k_q, rd_hi, wr_hi, echo_pos, echo_neg, k_rise, rd_cmd, wr_cmd;
  logic [7:0] up_cnt;
  logic [3:0] lanes;
  assign k_rise = main_timing_true && !k_q;
  assign rd_cmd = k_rise && !read_select_n && rd_hi;
  assign wr_cmd = k_rise && !write_select_n && wr_hi && !rd_cmd;
  assign lanes = {lane3_write_en_n, lane2_write_en_n, lane1_write_en_n, lane0_write_en_n};
  always_ff @(posedge ref_clk) begin
    k_q <= srst ? 1'b0 : main_timing_true;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_hi <= 1'b1;
      wr_hi <= 1'b1;
    end else if (k_rise) begin
      rd_hi <= read_select_n;
      wr_hi <= write_select_n;
    end
  end
  // Saturates, so lock and echo checks stay meaningful on long runs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      up_cnt <= 8'h00;
    end else if (up_cnt != 8'hFF) begin
      up_cnt <= up_cnt + 8'h01;
    end
  end
  // Echo follows whichever pair launches the read data
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      echo_pos <= 1'b0;
      echo_neg <= 1'b0;
    end else if (output_timing_true && output_timing_inv) begin
      echo_pos <= main_timing_true;
      echo_neg <= main_timing_inv;
    end else begin
      echo_pos <= output_timing_true;
      echo_neg <= output_timing_inv;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_read_four_beats: assert property (rd_cmd |-> ##4 output_bits_oe [*4])
    else $error("read burst did not drive four beats");
  a_oe_has_read: assert property ($rose(output_bits_oe) |-> $past(rd_cmd, 4))
    else $error("data outputs driven without a read");
  a_oe_after_lock: assert property (up_cnt < 8'hC8 |-> !output_bits_oe)
    else $error("data outputs driven before lock");
  a_read_spacing: assert property (rd_cmd |-> ##2 read_select_n)
    else $error("reads on consecutive clock rises");
  a_write_spacing: assert property (wr_cmd |-> ##2 write_select_n)
    else $error("writes on consecutive clock rises");
  a_write_no_read: assert property (!write_select_n |-> read_select_n)
    else $error("read select low during write");
  a_cmd_on_rise: assert property ($fell(read_select_n) |-> main_timing_true ##1 !read_select_n)
    else $error("read select not held over a clock period");
  a_lanes_in_write: assert property (lanes != 4'hF |->
    $past(wr_cmd, 2) || $past(wr_cmd, 3) || $past(wr_cmd, 4) || $past(wr_cmd, 5))
    else $error("lane enable outside write beats");
  a_echo_follows: assert property (up_cnt > 8'h02 |->
    returned_strobe_pos == echo_pos && returned_strobe_neg == echo_neg)
    else $error("echo strobes not following launch clocks");
  a_clocks_never_low: assert property (main_timing_true || main_timing_inv)
    else $error("both input clocks low");
  c_read: cover property (rd_cmd);
  c_write: cover property (wr_cmd);
  c_parked: cover property (main_timing_true && main_timing_inv && output_timing_true);
  c_held_read: cover property (output_timing_true && output_timing_inv && output_bits_oe);
endmodule

// ==== verification/test_burst4_split_port_sram_bus.sv ====
// Self-checking bench for both ends of the burst SRAM bus
`timescale 1ns/1ns
module test_burst4_split_port_sram_bus;
  localparam int AW = 6;
  logic ref_clk, srst, cmd_valid, cmd_write, cmd_ready, wr_valid, wr_ready, rd_valid;
  logic clk_run, out_clk_hold, link_ready;
  logic [AW-1:0] cmd_addr;
  logic [35:0] wr_data, rd_data;
  logic [3:0] wr_lane_en_n;
  int fail_count, tests_run, reads, oe_cycles;
  b4s_pkg::b4s_word_t mem [1 << (AW + 2)];
  b4s_pkg::b4s_word_t rdq [$];
  logic [39:0] pend [$];
  b4s_if #(.AW(AW)) b4s_if_i ();
  b4s_sram_dev #(.AW(AW)) b4s_sram_dev_i (.ref_clk(ref_clk), .srst(srst), .bus(b4s_if_i));
  b4s_ctl #(.AW(AW), .FIFO_DEPTH(8)) b4s_ctl_i (.ref_clk(ref_clk), .srst(srst), .bus(b4s_if_i),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_lane_en_n(wr_lane_en_n), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .clk_run(clk_run), .out_clk_hold(out_clk_hold),
    .link_ready(link_ready));
  b4s_chk b4s_chk_i (.ref_clk(ref_clk), .srst(srst),
    .main_timing_true(b4s_if_i.main_timing_true), .main_timing_inv(b4s_if_i.main_timing_inv),
    .output_timing_true(b4s_if_i.output_timing_true),
    .output_timing_inv(b4s_if_i.output_timing_inv),
    .read_select_n(b4s_if_i.read_select_n), .write_select_n(b4s_if_i.write_select_n),
    .lane0_write_en_n(b4s_if_i.lane0_write_en_n), .lane1_write_en_n(b4s_if_i.lane1_write_en_n),
    .lane2_write_en_n(b4s_if_i.lane2_write_en_n), .lane3_write_en_n(b4s_if_i.lane3_write_en_n),
    .output_bits_oe(b4s_if_i.output_bits_oe), .returned_strobe_pos(b4s_if_i.returned_strobe_pos),
    .returned_strobe_neg(b4s_if_i.returned_strobe_neg));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic b4s_pkg::b4s_word_t merge(input b4s_pkg::b4s_word_t old_w,
      input b4s_pkg::b4s_word_t new_w, input logic [3:0] en_n);
    b4s_pkg::b4s_word_t r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (!en_n[i]) begin
        r[i*9 +: 9] = new_w[i*9 +: 9];
      end
    end
    return r;
  endfunction
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic stall();
    fail_count++;
    $display("Wait limit used up at t=%0t", $time);
    give_verdict();
  endtask
  task automatic wait_link();
    for (int g = 0; link_ready !== 1'b1; g++) begin
      if (g > 400) stall();
      @(negedge ref_clk);
    end
  endtask
  // Lane mode 0 writes all lanes, 2 masks all, else random per beat
  task automatic push(input int k, input int mode, input int tries, output int n);
    logic [39:0] b;
    n = 0;
    for (int t = 0; t < tries && n < k; t++) begin
      @(negedge ref_clk);
      b[35:0] = 36'({$urandom, $urandom});
      b[39:36] = mode == 0 ? 4'h0 : (mode == 2 ? 4'hF : 4'($urandom_range(0, 15)));
      wr_data = b[35:0];
      wr_lane_en_n = b[39:36];
      wr_valid = wr_ready;
      if (wr_ready === 1'b1) begin
        pend.push_back(b);
        n++;
      end
    end
    @(negedge ref_clk);
    wr_valid = 1'b0;
  endtask
  task automatic issue(input bit wr, input logic [AW-1:0] a);
    logic [39:0] b;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    #1;
    for (int g = 0; cmd_ready !== 1'b1; g++) begin
      if (g > 100) stall();
      @(negedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      if (wr) begin
        b = pend.pop_front();
        mem[{a, 2'(i)}] = merge(mem[{a, 2'(i)}], b[35:0], b[39:36]);
      end else begin
        rdq.push_back(mem[{a, 2'(i)}]);
      end
    end
    reads += wr ? 0 : 1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    check({b4s_if_i.read_select_n, b4s_if_i.write_select_n, b4s_if_i.addr},
      {wr ? 2'b10 : 2'b01, a});
  endtask
  always @(negedge ref_clk) begin
    if (b4s_if_i.output_bits_oe === 1'b1) begin
      oe_cycles++;
    end
    if (rd_valid === 1'b1) begin
      check(rd_data, rdq.pop_front());
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    logic [AW-1:0] blk;
    n = $urandom(32'h6FB73A04);
    {srst, clk_run} = 2'b11;
    {cmd_valid, cmd_write, wr_valid, out_clk_hold} = 4'h0;
    cmd_addr = '0;
    wr_data = '0;
    wr_lane_en_n = 4'hF;
    {fail_count, tests_run, reads, oe_cycles} = '0;
    repeat (6) @(negedge ref_clk);
    srst = 1'b0;
    push(12, 0, 16, n);
    check(n, 8);
    check(wr_ready, 1'b0);
    check(b4s_if_i.output_bits_oe, 1'b0);
    wait_link();
    $display("Test buffer fill and lock done");
    issue(1'b1, '0);
    issue(1'b1, '1);
    push(4, 2, 40, n);
    issue(1'b1, '0);
    issue(1'b0, '0);
    issue(1'b0, '1);
    $display("Test boundary blocks and masked write done");
    for (int i = 0; i < 12; i++) begin
      blk = i[0] ? '1 : '0;
      push(4, 1, 40, n);
      issue(1'b0, ~blk);
      issue(1'b1, blk);
      issue(1'b0, ~blk);
      repeat (8) @(negedge ref_clk);
      issue(1'b0, blk);
    end
    $display("Test random lane writes done");
    repeat (12) @(negedge ref_clk);
    clk_run = 1'b0;
    repeat (20) @(negedge ref_clk);
    check({b4s_if_i.main_timing_true, b4s_if_i.main_timing_inv,
      b4s_if_i.output_timing_true, b4s_if_i.output_timing_inv}, 4'hF);
    clk_run = 1'b1;
    wait_link();
    issue(1'b0, '0);
    $display("Test clock park done");
    out_clk_hold = 1'b1;
    repeat (4) @(negedge ref_clk);
    check({b4s_if_i.output_timing_true, b4s_if_i.output_timing_inv}, 2'b11);
    issue(1'b0, '1);
    repeat (12) @(negedge ref_clk);
    out_clk_hold = 1'b0;
    $display("Test held output clocks done");
    for (int g = 0; rdq.size() != 0 && g < 50; g++) begin
      @(negedge ref_clk);
    end
    check(rdq.size(), 0);
    check(oe_cycles, reads * 4);
    give_verdict();
  end
endmodule
